// *** hdl/eit_pkg.sv ***
// Package with register map, field layouts and constants of the interval and event timer block
// Notes on behaviour
// [RL1] Interval mode raises match interrupt every interval
// [RL2] Software stops, configures, then enables the timer
// [RL3] On match counter returns to 00H, continues
// [RL4] Match interrupt raised in clearing cycle; timerMatchIrq and irq here rise one cycle after the clear
// [RL5] Software stops timer before changing clock select
// [RL6] Software keeps output disabled during setup
// [RL7] First timer clock select: fx, /8, /128, sub, chain
// [RL8] Second timer clock select: fx, /4, external dividers
// [RL9] Third timer clock select: fx, /16, external dividers
// [RL10] Interval spans one to 256 count periods
// [RL11] Only second and third timers count events
// [RL12] Event setup order: stop, configure, then enable
// [RL13] Software sets pin direction to input
// [RL14] Event mode increments on each valid edge
// [RL15] Event match clears counter and raises interrupt
// [RL16] Clearing enable zeroes counter and halts counting
// [RL17] Mode code 00 selects stand-alone 8-bit counter
// [RL18] Counter advances once per selected count clock
package eit_pkg;
	localparam int          NTIM         = 3;          // Number of timers
	localparam int          CNT_W        = 8;          // Counter width
	localparam logic [11:0] ADDR_CTRL0   = 12'h000;    // Control of first timer
	localparam logic [11:0] ADDR_CTRL1   = 12'h004;    // Control of second timer
	localparam logic [11:0] ADDR_CTRL2   = 12'h008;    // Control of third timer
	localparam logic [11:0] ADDR_CMP0    = 12'h00c;    // Compare values, one per word
	localparam logic [11:0] ADDR_CMP1    = 12'h010;
	localparam logic [11:0] ADDR_CMP2    = 12'h014;
	localparam logic [11:0] ADDR_CNT0    = 12'h018;    // Read-only count values
	localparam logic [11:0] ADDR_CNT1    = 12'h01c;
	localparam logic [11:0] ADDR_CNT2    = 12'h020;
	localparam logic [11:0] ADDR_STAT    = 12'h024;    // Sticky match status, read only
	localparam logic [11:0] ADDR_CLR     = 12'h028;    // Write one to clear status
	localparam logic [11:0] ADDR_IEN     = 12'h02c;    // Interrupt enable
	// Control word layout
	localparam int          CTL_OE       = 0;          // Output enable bit
	localparam int          CTL_MODE_LO  = 1;          // Two bit mode field
	localparam int          CTL_CSEL_LO  = 3;          // Three bit clock select
	localparam int          CTL_EN       = 7;          // Count enable
	localparam logic [7:0]  CTL_RST      = 8'h00;
	localparam logic [7:0]  CMP_RST      = 8'h00;
	localparam logic [1:0]  MODE_8BIT    = 2'h0;
	localparam logic [31:0] ZERO32       = 32'h0000_0000;
	// Clock select codes
	localparam logic [2:0]  CS_FX        = 3'h0;
	localparam logic [2:0]  CS_DIVA      = 3'h1;
	localparam logic [2:0]  CS_C2        = 3'h2;
	localparam logic [2:0]  CS_C3        = 3'h3;
	localparam logic [2:0]  CS_C4        = 3'h4;
	localparam logic [2:0]  CS_C5        = 3'h5;
	// Prescaler taps
	localparam int          PRE_W        = 7;          // Prescaler covers divide by 128
	localparam int          TAP_D4       = 1;
	localparam int          TAP_D8       = 2;
	localparam int          TAP_D16      = 3;
	localparam int          TAP_D128     = 6;
	localparam int          EXT_W        = 3;          // External divider width
endpackage : eit_pkg

// *** hdl/eit_tick_if.sv ***
// Interface carrying per-timer tick and status between top and counter slices
`timescale 1ns/1ps
`default_nettype none
interface eit_tick_if;
	logic       tick;      // One-cycle count clock pulse
	logic       enable;    // Count enable level
	logic [7:0] cmpVal;    // Compare value
	logic [7:0] cntVal;    // Current count
	logic       match;     // Match pulse, counter clears

	modport top (output tick, output enable, output cmpVal, input cntVal, input match);
	modport slice (input tick, input enable, input cmpVal, output cntVal, output match);
endinterface : eit_tick_if
`default_nettype wire

// *** hdl/eit_counter.sv ***
// One 8-bit timer counter slice with compare clear
`timescale 1ns/1ps
`default_nettype none
module eit_counter (
	input  wire logic    clock,
	input  wire logic    nrst,
	eit_tick_if.slice    tk
);
	logic [7:0] cnt_r;     // Count register
	logic       match_r;   // Match pulse register
	logic [7:0] cnt_nxt;
	logic       hit;       // Count has reached compare on this tick

	assign hit     = tk.tick && (cnt_r == tk.cmpVal);                      // [RL3]
	// Clear on match keeps interval at compare plus one ticks
	assign cnt_nxt = !tk.enable ? 8'h00 :                                   // [RL16]
	                 hit        ? 8'h00 :                                   // [RL3] [RL15] [RL10]
	                 tk.tick    ? cnt_r + 8'h01 : cnt_r;                    // [RL18] [RL14]

	// Counter and match pulse
	always_ff @(posedge clock) begin
		if (!nrst) begin
			cnt_r   <= 8'h00;
			match_r <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			match_r <= tk.enable && hit;                                      // [RL4] [RL1]
		end
	end

	assign tk.cntVal = cnt_r;
	assign tk.match  = match_r;
endmodule : eit_counter
`default_nettype wire

// *** hdl/eit_top.sv ***
// Top of three 8-bit interval and event timers with APB register slave
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module eit_top #(
	parameter int DUMMY_W = 8     // Unused; counters are fixed at 8 bits
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        subClockIn,        // Subsystem clock, asynchronous
	input  wire logic [1:0]  externalCountInput, // Event pins of second and third timers
	output logic             irq,
	output logic      [2:0]  timerMatchIrq,     // Per-timer match pulse
	output logic      [2:0]  timerOutputEnable  // Output enable bits as set
);
	// Block overview
	// Three independent 8-bit timers share one APB slave port.
	// Every timer owns a control byte, a compare byte and a count.
	// The count word is read only; writes to it are ignored.
	// Each register sits in the low bits of its own 32-bit word.
	// Upper bits of every read word return zero.
	// An address above the last register or not word aligned
	// answers with an error and changes nothing.
	//
	// Control byte layout
	// Bit 0 copies straight to the output enable port.
	// Bits 2 to 1 pick the mode; only code zero counts here.
	// Bits 5 to 3 pick the count clock source.
	// Bit 7 starts counting; clearing it zeroes the counter.
	// Other mode codes leave the timer stopped and quiet.
	//
	// Count clock sources
	// All sources become one-cycle tick pulses on the main clock.
	// Main clock codes give a tick every cycle.
	// Divided codes tap a shared free-running prescaler.
	// The prescaler never stops, so the first tick after an
	// enable may arrive early; the phase is not restarted.
	// The subsystem clock is sampled, so it must stay well
	// below half the main clock rate or edges are lost.
	// The first timer can chain on match pulses of the second.
	// Its last code ticks on every second match of the second
	// timer, the falling edge of that timer's square wave.
	//
	// External count inputs
	// Each pin passes two flip-flops before any logic reads it.
	// A rising edge after the sync stages is a valid edge.
	// A pin pulse must stay high and low for at least two main
	// clock cycles each, otherwise edges may be missed.
	// The per-pin dividers restart whenever their timer stops,
	// so a divided count begins on a clean boundary.
	// Counting follows the pin with about three cycles of lag.
	//
	// Compare and match
	// A tick with count equal to compare clears the count.
	// The same edge raises an internal one-cycle match pulse.
	// The interval is therefore compare plus one ticks.
	// A compare of zero gives a match on every tick.
	// Changing compare while running may let the count wrap
	// through all 256 values before the next match.
	//
	// Status and interrupt
	// Match pulses set sticky status bits one cycle later.
	// Writing ones to the clear word drops the chosen bits.
	// A match in the same cycle as a clear keeps its bit set,
	// so no event is ever lost to a late clear.
	// The interrupt line is high while an enabled bit is set.
	// It follows the next status value, so it rises together
	// with the status bit rather than a cycle after it.
	//
	// Bus timing
	// Read data are captured in the setup cycle and shown with
	// ready in the access cycle; ready lasts a single cycle.
	// Writes land at the access edge where ready is high, so a
	// master that aborts before ready changes nothing.
	// Read data and error are zero whenever ready is low.
	//
	// Limitations
	// No pin drive logic lives here; enables are only copied.
	// Cascaded and pulse output modes are not provided.
	// Clock select must not change while a timer runs; the
	// tick mux is not glitch safe across a reselect.

	// Registers
	logic [7:0]  ctrl_r [3];      // Control words
	logic [7:0]  cmp_r [3];       // Compare values
	logic [2:0]  stat_r;          // Sticky status
	logic [2:0]  ien_r;           // Interrupt enables
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        irq_r;
	logic [2:0]  matchIrq_r;
	logic [2:0]  oe_r;
	logic [eit_pkg::PRE_W-1:0] pre_r;   // Main clock prescaler
	logic [2:0]  sub_r;                 // Two sync stages plus edge history
	logic [2:0]  ext_r [2];             // Sync stages plus history per pin
	logic [eit_pkg::EXT_W-1:0] extDiv_r [2]; // External dividers

	// Prescaler pulses: low bits all one means divider wraps next edge
	function automatic logic preTick(input logic [eit_pkg::PRE_W-1:0] p, input int tap);
		logic r;
		r = 1'b1;
		for (int i = 0; i < eit_pkg::PRE_W; i++) begin
			if (i <= tap)
				r = r & p[i];
		end
		return r;
	endfunction

	logic [eit_pkg::PRE_W-1:0] pre_nxt;
	logic d4;
	logic d8;
	logic d16;
	logic d128;
	assign pre_nxt = pre_r + 7'h01;
	assign d4   = preTick(pre_r, eit_pkg::TAP_D4);
	assign d8   = preTick(pre_r, eit_pkg::TAP_D8);
	assign d16  = preTick(pre_r, eit_pkg::TAP_D16);
	assign d128 = preTick(pre_r, eit_pkg::TAP_D128);

	// Rising edge of subsystem clock, read only after two stages
	logic subTick;
	assign subTick = sub_r[1] && !sub_r[2];

	// External edges and divider pulses
	logic extEdge [2];
	logic [eit_pkg::EXT_W-1:0] extDiv_nxt [2];
	logic ext2 [2];
	logic ext4 [2];
	logic ext8 [2];
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gExt
			assign extEdge[g]    = ext_r[g][1] && !ext_r[g][2];          // [RL14]
			assign extDiv_nxt[g] = extEdge[g] ? extDiv_r[g] + 3'h1 : extDiv_r[g];
			assign ext2[g] = extEdge[g] && extDiv_r[g][0];
			assign ext4[g] = extEdge[g] && (extDiv_r[g][1:0] == 2'h3);
			assign ext8[g] = extEdge[g] && (extDiv_r[g] == 3'h7);
		end
	endgenerate

	// Timer slices
	eit_tick_if tk [3] ();
	logic [2:0] tickSel;
	logic [2:0] matchW;
	logic [2:0] csel [3];
	logic       enW [3];
	// Square-wave state of second timer, used as first timer source
	logic       sq1_r;

	generate
		for (g = 0; g < 3; g++) begin : gTim
			assign csel[g] = ctrl_r[g][eit_pkg::CTL_CSEL_LO +: 3];
			// Only stand-alone mode counts here
			assign enW[g] = ctrl_r[g][eit_pkg::CTL_EN] &&
			                (ctrl_r[g][eit_pkg::CTL_MODE_LO +: 2] == eit_pkg::MODE_8BIT); // [RL17] [RL16]
			assign tk[g].tick   = tickSel[g];
			assign tk[g].enable = enW[g];
			assign tk[g].cmpVal = cmp_r[g];
			assign matchW[g]    = tk[g].match;
			eit_counter uCnt (
				.clock (clock),
				.nrst  (nrst),
				.tk    (tk[g])
			);
		end
	endgenerate

	// First timer source: may chain on second timer
	assign tickSel[0] = (csel[0] == eit_pkg::CS_FX)   ? 1'b1 :          // [RL7]
	                    (csel[0] == eit_pkg::CS_DIVA) ? d8 :
	                    (csel[0] == eit_pkg::CS_C2)   ? d128 :
	                    (csel[0] == eit_pkg::CS_C3)   ? subTick :
	                    (csel[0] == eit_pkg::CS_C4)   ? matchW[1] :
	                    (csel[0] == eit_pkg::CS_C5)   ? (matchW[1] && sq1_r) : 1'b0;
	// Second and third timers: external count input only here
	assign tickSel[1] = (csel[1] == eit_pkg::CS_FX)   ? 1'b1 :          // [RL8] [RL11]
	                    (csel[1] == eit_pkg::CS_DIVA) ? d4 :
	                    (csel[1] == eit_pkg::CS_C2)   ? extEdge[0] :
	                    (csel[1] == eit_pkg::CS_C3)   ? ext2[0] :
	                    (csel[1] == eit_pkg::CS_C4)   ? ext4[0] :
	                    (csel[1] == eit_pkg::CS_C5)   ? ext8[0] : 1'b0;
	assign tickSel[2] = (csel[2] == eit_pkg::CS_FX)   ? 1'b1 :          // [RL9] [RL11]
	                    (csel[2] == eit_pkg::CS_DIVA) ? d16 :
	                    (csel[2] == eit_pkg::CS_C2)   ? extEdge[1] :
	                    (csel[2] == eit_pkg::CS_C3)   ? ext2[1] :
	                    (csel[2] == eit_pkg::CS_C4)   ? ext4[1] :
	                    (csel[2] == eit_pkg::CS_C5)   ? ext8[1] : 1'b0;

	// APB decode; zero wait states
	logic        setup;
	logic        wrAcc;
	logic        rdAcc;
	logic        hitMap;
	logic [31:0] rdMux;
	assign setup  = psel && !penable;
	assign wrAcc  = psel && penable && pready_r && pwrite;   // Lands at the ready edge
	assign rdAcc  = setup && !pwrite;
	assign hitMap = (paddr <= eit_pkg::ADDR_IEN) && (paddr[1:0] == 2'h0);
	assign rdMux  = (paddr == eit_pkg::ADDR_CTRL0) ? {24'h0, ctrl_r[0]} :
	                (paddr == eit_pkg::ADDR_CTRL1) ? {24'h0, ctrl_r[1]} :
	                (paddr == eit_pkg::ADDR_CTRL2) ? {24'h0, ctrl_r[2]} :
	                (paddr == eit_pkg::ADDR_CMP0)  ? {24'h0, cmp_r[0]} :
	                (paddr == eit_pkg::ADDR_CMP1)  ? {24'h0, cmp_r[1]} :
	                (paddr == eit_pkg::ADDR_CMP2)  ? {24'h0, cmp_r[2]} :
	                (paddr == eit_pkg::ADDR_CNT0)  ? {24'h0, tk[0].cntVal} :
	                (paddr == eit_pkg::ADDR_CNT1)  ? {24'h0, tk[1].cntVal} :
	                (paddr == eit_pkg::ADDR_CNT2)  ? {24'h0, tk[2].cntVal} :
	                (paddr == eit_pkg::ADDR_STAT)  ? {29'h0, stat_r} :
	                (paddr == eit_pkg::ADDR_IEN)   ? {29'h0, ien_r} : eit_pkg::ZERO32;

	// Status: set beats a clear in the same cycle
	logic [2:0] clrMask;
	logic [2:0] stat_nxt;
	assign clrMask  = (wrAcc && paddr == eit_pkg::ADDR_CLR) ? pwdata[2:0] : 3'h0;
	assign stat_nxt = (stat_r & ~clrMask) | matchW;

	// Synchronisers and dividers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			pre_r       <= '0;
			sub_r       <= 3'h0;
			ext_r[0]    <= 3'h0;
			ext_r[1]    <= 3'h0;
			extDiv_r[0] <= '0;
			extDiv_r[1] <= '0;
		end else begin
			pre_r       <= pre_nxt;
			sub_r       <= {sub_r[1:0], subClockIn};
			ext_r[0]    <= {ext_r[0][1:0], externalCountInput[0]};
			ext_r[1]    <= {ext_r[1][1:0], externalCountInput[1]};
			// Dividers restart when the timer is stopped
			extDiv_r[0] <= enW[1] ? extDiv_nxt[0] : 3'h0;
			extDiv_r[1] <= enW[2] ? extDiv_nxt[1] : 3'h0;
		end
	end

	// Second timer square wave toggles on its match
	always_ff @(posedge clock) begin
		if (!nrst)
			sq1_r <= 1'b0;
		else if (!enW[1])
			sq1_r <= 1'b0;
		else if (matchW[1])
			sq1_r <= !sq1_r;
	end

	// Configuration registers; software must stop before reselecting clock
	always_ff @(posedge clock) begin
		if (!nrst) begin
			for (int i = 0; i < 3; i++) begin
				ctrl_r[i] <= eit_pkg::CTL_RST;
				cmp_r[i]  <= eit_pkg::CMP_RST;
			end
			ien_r <= 3'h0;
		end else if (wrAcc) begin
			if (paddr == eit_pkg::ADDR_CTRL0)
				ctrl_r[0] <= pwdata[7:0];
			else if (paddr == eit_pkg::ADDR_CTRL1)
				ctrl_r[1] <= pwdata[7:0];
			else if (paddr == eit_pkg::ADDR_CTRL2)
				ctrl_r[2] <= pwdata[7:0];
			else if (paddr == eit_pkg::ADDR_CMP0)
				cmp_r[0] <= pwdata[7:0];
			else if (paddr == eit_pkg::ADDR_CMP1)
				cmp_r[1] <= pwdata[7:0];
			else if (paddr == eit_pkg::ADDR_CMP2)
				cmp_r[2] <= pwdata[7:0];
			else if (paddr == eit_pkg::ADDR_IEN)
				ien_r <= pwdata[2:0];
		end
	end

	// Bus answer, status and outputs
	always_ff @(posedge clock) begin
		if (!nrst) begin
			prdata_r   <= eit_pkg::ZERO32;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			stat_r     <= 3'h0;
			irq_r      <= 1'b0;
			matchIrq_r <= 3'h0;
			oe_r       <= 3'h0;
		end else begin
			pready_r   <= setup;
			pslverr_r  <= setup && !hitMap;
			prdata_r   <= rdAcc ? rdMux : eit_pkg::ZERO32;
			stat_r     <= stat_nxt;
			irq_r      <= |(stat_nxt & ien_r);
			matchIrq_r <= matchW;                                            // [RL4]
			oe_r       <= {ctrl_r[2][eit_pkg::CTL_OE], ctrl_r[1][eit_pkg::CTL_OE], ctrl_r[0][eit_pkg::CTL_OE]};
		end
	end

	assign prdata            = prdata_r;
	assign pready            = pready_r;
	assign pslverr           = pslverr_r;
	assign irq               = irq_r;
	assign timerMatchIrq     = matchIrq_r;
	assign timerOutputEnable = oe_r;
endmodule : eit_top
`default_nettype wire

// *** tb/eit_pulse_src.sv ***
// Partner model: pulse source on one external count pin
`timescale 1ns/1ps
`default_nettype none
module eit_pulse_src (
	input  wire logic       clock,
	input  wire logic       go,
	input  wire logic [7:0] count,
	output var  logic       pin,
	output var  logic       busy
);
	logic [7:0] left_r;      // Pulses still to send
	logic [2:0] ph_r;        // Phase in a six cycle pulse
	initial begin
		pin = 1'b0;
		busy = 1'b0;
		left_r = 8'h00;
		ph_r = 3'h0;
	end
	// Pulses three cycles high and three low, wide enough to pass the two stage sync
	always @(posedge clock) begin
		if (go && !busy) begin
			left_r <= count;
			busy <= count != 8'h00;
			ph_r <= 3'h0;
		end else if (busy) begin
			ph_r <= ph_r + 3'h1;
			if (ph_r == 3'h2) pin <= 1'b1;
			if (ph_r == 3'h5) begin
				pin <= 1'b0;
				ph_r <= 3'h0;
				left_r <= left_r - 8'h01;
				busy <= left_r != 8'h01;
			end
		end
	end
endmodule // eit_pulse_src
`default_nettype wire

// *** tb/eit_top_props.sv ***
// Port level checks of the interval and event timer block
`timescale 1ns/1ps
`default_nettype none
module eit_top_props (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [2:0]  timerMatchIrq,
	input wire logic [2:0]  timerOutputEnable
);
	wire logic wrDone = psel && penable && pready && pwrite;       // Write taking effect
	wire logic wrCtl0 = wrDone && paddr == eit_pkg::ADDR_CTRL0;
	wire logic wrCmp0 = wrDone && paddr == eit_pkg::ADDR_CMP0;
	logic [8:0] since_r;   // Cycles since the last first-timer match
	logic [7:0] cmp_r;     // Last compare value written
	logic       fx_r;      // First timer runs on the main clock
	logic       primed_r;  // A match was seen since the last setup write
	// Interval tracker; any setup write forgets the old interval
	always_ff @(posedge clock) begin
		if (!nrst) begin
			since_r <= 9'h000;
			cmp_r <= 8'h00;
			fx_r <= 1'b0;
			primed_r <= 1'b0;
		end else begin
			since_r <= timerMatchIrq[0] ? 9'h001 : since_r + 9'h001;
			primed_r <= (wrCtl0 || wrCmp0) ? 1'b0 : (primed_r || timerMatchIrq[0]);
			if (wrCmp0) cmp_r <= pwdata[7:0];
			if (wrCtl0) fx_r <= pwdata[7:0] == 8'h80;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	interval_len_a: assert property (timerMatchIrq[0] && primed_r && fx_r |-> since_r == {1'b0, cmp_r} + 9'h001)
		else $error("interval length wrong");
	stop_quiet_a: assert property (wrCtl0 && !pwdata[7] |-> ##3 !timerMatchIrq[0])
		else $error("match after stop");
	mode_off_a: assert property (wrCtl0 && pwdata[2:1] != 2'h0 |-> ##3 !timerMatchIrq[0] [*3])
		else $error("match in other mode");
	oe_copy_a: assert property (wrCtl0 && pwdata[0] |-> ##[1:2] timerOutputEnable[0])
		else $error("output enable not shown");
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no ready in access");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready too long");
	idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
		else $error("data outside answer");
	unmapped_err_a: assert property (psel && !penable && paddr > eit_pkg::ADDR_IEN |=> pslverr && prdata == 32'h0)
		else $error("unmapped not refused");
	reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> timerMatchIrq == 3'h0 && !pready)
		else $error("outputs active in reset");
endmodule // eit_top_props
bind eit_top eit_top_props u_eit_top_props (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.timerMatchIrq(timerMatchIrq), .timerOutputEnable(timerOutputEnable));
`default_nettype wire

// *** tb/tb_eit_top.sv ***
// Self-checking bench of the interval and event timer block
`timescale 1ns/1ps
`default_nettype none
module tb_eit_top;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;      // Active low
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, irq, err;
	logic        subClk = 1'b0;    // Ten cycle period
	logic [2:0]  tmi, toe;
	logic [1:0]  go = 2'h0;
	logic [7:0]  nPulse = 8'h00;
	wire  logic [1:0] ext, busy;
	int          num_errors = 0, samples_checked = 0, seed = 32'hec4d, sc = 0;
	always #12.5 clock = ~clock;
	// Subsystem clock, deliberately much slower than the main clock
	always @(posedge clock) begin
		sc <= (sc == 4) ? 0 : sc + 1;
		if (sc == 4) subClk <= ~subClk;
	end
	eit_top u_eit_top (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .subClockIn(subClk),
		.externalCountInput(ext), .irq(irq), .timerMatchIrq(tmi), .timerOutputEnable(toe));
	eit_pulse_src u_eit_pulse_src0 (.clock(clock), .go(go[0]), .count(nPulse), .pin(ext[0]), .busy(busy[0]));
	eit_pulse_src u_eit_pulse_src1 (.clock(clock), .go(go[1]), .count(nPulse), .pin(ext[1]), .busy(busy[1]));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; waits for pready, takes data at that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Stop, load compare, pick mode and clock, then enable
	task cfg(input int t, input int code, input int c, input logic oe);
		apb(1'b1, 12'(4 * t), 32'h0);
		apb(1'b1, 12'(12 + 4 * t), 32'(c));
		apb(1'b1, 12'(4 * t), 32'(code << 3));
		apb(1'b1, 12'(4 * t), 32'(8'h80 | (code << 3) | oe));
	endtask
	function int ivl(input int d, input int c);
		return d * (c + 1);
	endfunction
	// Cycles between two consecutive match pulses of timer t
	task gap(input int t, output int n);
		int k;
		k = 0;
		while (tmi[t] !== 1'b1 && k < 40000) begin @(posedge clock); k++; end
		@(posedge clock);
		n = 1;
		while (tmi[t] !== 1'b1 && n < 40000) begin @(posedge clock); n++; end
	endtask
	// Pin edges need the sync stages to drain, hence the settle wait
	task pulses(input int p, input int cnt);
		int k;
		@(posedge clock);
		nPulse <= 8'(cnt);
		go[p] <= 1'b1;
		@(posedge clock);
		go[p] <= 1'b0;
		k = 0;
		@(posedge clock);
		while (busy[p] === 1'b1 && k < 5000) begin @(posedge clock); k++; end
		repeat (8) @(posedge clock);
	endtask
	task end_sim;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clock);
		num_errors++;
		$display("ERROR %0t: run took too long", $time);
		end_sim;
	end
	initial begin
		int tT[10] = '{0, 0, 0, 0, 0, 0, 2, 2, 1, 1};       // Timer, code, division
		int tC[10] = '{0, 1, 2, 3, 4, 5, 0, 1, 1, 0};
		int tD[10] = '{1, 8, 128, 10, 2, 4, 1, 16, 4, 1};
		int n, c, d, k, p;
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		for (k = 0; k < 'h28; k += 4) begin apb(1'b0, 12'(k), 32'h0); chk(rd, 32'h0); end
		apb(1'b1, 12'h030, 32'h1);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 12'h030, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, eit_pkg::ADDR_CNT0, 32'h5);                 // Read-only count
		apb(1'b0, eit_pkg::ADDR_CNT0, 32'h0);
		chk(rd, 32'h0);
		$display("test reset finished");
		cfg(1, 0, 1, 1'b0);                                   // Second timer feeds the chain codes
		for (k = 0; k < 10; k++) begin
			c = (k == 0) ? 0 : ($random(seed) & 3);
			cfg(tT[k], tC[k], c, k[0]);
			gap(tT[k], n);
			chk(32'(n), 32'(ivl(tD[k], c)));
			apb(1'b1, 12'(4 * tT[k]), 32'h0);
			apb(1'b0, 12'(24 + 4 * tT[k]), 32'h0);
			chk(rd, 32'h0);
		end
		cfg(2, 0, 8'hff, 1'b0);
		gap(2, n);
		chk(32'(n), 32'd256);
		apb(1'b1, eit_pkg::ADDR_CTRL2, 32'h0);
		apb(1'b1, eit_pkg::ADDR_CLR, 32'h7);
		apb(1'b1, eit_pkg::ADDR_CMP0, 32'h0);
		apb(1'b1, eit_pkg::ADDR_CTRL0, 32'h82);
		repeat (20) @(posedge clock);
		apb(1'b0, eit_pkg::ADDR_STAT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, eit_pkg::ADDR_CTRL0, 32'h0);
		$display("test interval finished");
		for (k = 2; k < 6; k++) begin
			for (p = 0; p < 2; p++) begin
				d = 1 << (k - 2);
				cfg(p + 1, k, 8'hff, 1'b0);
				n = d * (1 + ($random(seed) & 3));
				pulses(p, n);
				apb(1'b0, 12'(28 + 4 * p), 32'h0);
				chk(rd, 32'(n / d));
				apb(1'b1, 12'(4 + 4 * p), 32'h0);
			end
		end
		apb(1'b1, eit_pkg::ADDR_IEN, 32'h4);
		cfg(2, 2, 2, 1'b0);
		pulses(1, 3);
		apb(1'b0, eit_pkg::ADDR_CNT2, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, eit_pkg::ADDR_STAT, 32'h0);
		chk(rd, 32'h4);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, eit_pkg::ADDR_IEN, 32'h0);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, eit_pkg::ADDR_CTRL2, 32'h0);
		apb(1'b1, eit_pkg::ADDR_CLR, 32'h4);
		apb(1'b0, eit_pkg::ADDR_STAT, 32'h0);
		chk(rd, 32'h0);
		$display("test events finished");
		end_sim;
	end
endmodule // tb_eit_top
`default_nettype wire
